//--- logic/debug_port_map.svh
// Register selection codes, instruction codes and bit positions of the
// two-wire debug port. Definitions only; included by bare name.
`ifndef DEBUG_PORT_MAP_SVH
`define DEBUG_PORT_MAP_SVH

// Selection values written into the target select register
`define SEL_DEVICE_ID   8'h00
`define SEL_REVISION    8'h01
`define SEL_HALT_CTRL   8'h02
`define SEL_PROG_CTRL   8'hDF
`define SEL_PROG_DATA   8'hBF
`define SEL_PROG_STAT   8'hB7
`define SEL_ADDR_HIGH   8'hAF
`define SEL_ADDR_LOW    8'hAE
`define SEL_CHECK_0     8'hA9
`define SEL_CHECK_1     8'hAA
`define SEL_CHECK_2     8'hAB
`define SEL_CHECK_3     8'hAC

// Two-bit instruction codes of a frame (bit 0 sent first)
`define INS_DATA_RD     2'h0
`define INS_ADDR_RD     2'h1
`define INS_DATA_WR     2'h2
`define INS_ADDR_WR     2'h3

// Field positions
`define BUSY_BIT        7
`define WR_LOCKED_BIT   7
`define RD_LOCKED_BIT   6
`define ERROR_BIT       0
`define HALT_BIT        0
`define PROG_EN_BIT     0

// Reset value and frame counts
`define RST_BYTE        8'h00
`define CNT_INS_LAST    3'h1
`define CNT_BYTE_LAST   3'h7
`define CNT_ZERO        3'h0

`endif

//--- logic/debug_port_pkg.sv
// Types shared by the two-wire debug port logic.
// Assumes debug_port_map.svh supplies all numeric constants.
package debug_port_pkg;

  // Frame state, one-hot
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_INSTR = 4'h2,
    ST_WDATA = 4'h4,
    ST_RDATA = 4'h8
  } frame_state_t;

endpackage

//--- logic/two_wire_debug_register_select.sv
// Device end of the two-pin debug and programming port: frame decoder,
// target select register, debug registers and programming sequencer.
// Assumes the adapter clock and data pins are asynchronous to i_mclk and
// that the adapter clock half period spans at least four i_mclk cycles.
`timescale 1ns/1ps
`include "debug_port_map.svh"

module two_wire_debug_register_select #(
  parameter logic [7:0] DEVICE_ID   = 8'h5A,  // Arbitrary neutral value
  parameter logic [7:0] REVISION_ID = 8'h00   // Arbitrary neutral value
) (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic        i_debug_clock_line,  // Adapter clock pin
  input  wire logic        i_debug_data_line,   // Data pin, input side
  output logic             o_debug_data_line,   // Data pin, output side
  output logic             o_debug_data_oe,     // High while device drives
  output logic             o_cpu_halt,          // Halt request to core
  output logic             o_mem_req,           // Programming op pending
  output logic             o_mem_we,            // Op is a write
  output logic [15:0]      o_mem_addr,          // Programming address
  output logic [7:0]       o_mem_wdata,         // Byte to program
  input  wire logic        i_mem_ack,           // Op finished, one pulse
  input  wire logic [7:0]  i_mem_rdata,         // Byte read, valid on ack
  input  wire logic        i_wr_locked,         // Current address write-locked
  input  wire logic        i_rd_locked          // Current address read-locked
);
  import debug_port_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic       ck_s1_reg;    // First stage, read only by ck_s2_reg
  logic       ck_s2_reg;    // Settled clock level
  logic       ck_s3_reg;    // Delayed copy for edge finding
  logic       dt_s1_reg;    // First stage, read only by dt_s2_reg
  logic       dt_s2_reg;    // Settled data level

  // Both pins share the same delay so data stays aligned to its edge
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ck_s1_reg <= 1'b0;
      ck_s2_reg <= 1'b0;
      ck_s3_reg <= 1'b0;
      dt_s1_reg <= 1'b1;
      dt_s2_reg <= 1'b1;
    end else begin
      ck_s1_reg <= i_debug_clock_line;
      ck_s2_reg <= ck_s1_reg;
      ck_s3_reg <= ck_s2_reg;
      dt_s1_reg <= i_debug_data_line;
      dt_s2_reg <= dt_s1_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Storage
  frame_state_t state_reg;        // Frame position
  frame_state_t state_next;
  logic [2:0]   cnt_reg;          // Bit counter within a field
  logic [2:0]   cnt_next;
  logic         ins0_reg;         // First instruction bit
  logic [7:0]   shift_reg;        // Serial shifter, both directions
  logic [7:0]   shift_next;
  logic [7:0]   select_reg;       // Target select register
  logic [7:0]   halt_reg;         // Halt control register
  logic [7:0]   prog_ctrl_reg;    // Programming control register
  logic [7:0]   prog_data_reg;    // Programming data register
  logic [7:0]   addr_hi_reg;      // Programming address high byte
  logic [7:0]   addr_lo_reg;      // Programming address low byte
  logic [7:0]   check_reg [4];    // Check bytes zero to three
  logic         busy_reg;         // Programming op in progress
  logic         we_reg;           // Pending op is a write
  logic         error_reg;        // Last op refused: address locked, core not halted or writes not enabled

  //////////////////////////////////////////////////////////////////////////
  // Decoding
  wire       ck_rise   = ck_s2_reg & ~ck_s3_reg;              // Sampling edge
  wire [1:0] ins_now   = {dt_s2_reg, ins0_reg};               // Full instruction
  wire [7:0] wr_byte   = {dt_s2_reg, shift_reg[7:1]};         // Last bit arriving
  wire       last_ins  = (state_reg == ST_INSTR) && ck_rise && (cnt_reg == `CNT_INS_LAST);
  wire       last_wbit = (state_reg == ST_WDATA) && ck_rise && (cnt_reg == `CNT_BYTE_LAST);
  wire       rd_fire   = last_ins && !ins_now[1];             // Read begins
  wire       wr_data   = last_wbit && (ins0_reg == 1'b0);     // Data write done
  wire       wr_addr   = last_wbit && (ins0_reg == 1'b1);     // Select write done
  wire       rd_data   = rd_fire && (ins_now == `INS_DATA_RD);
  wire       sel_pdata = (select_reg == `SEL_PROG_DATA);

  // Status of the address under the programming address
  wire [7:0] prog_status = {i_wr_locked, i_rd_locked, 5'h00, error_reg};
  wire [7:0] busy_status = {busy_reg, 7'h00};

  // Data read selection; unknown selections read zero
  logic [7:0] data_mux;
  always_comb begin
    unique case (select_reg)
      `SEL_DEVICE_ID: data_mux = DEVICE_ID;
      `SEL_REVISION:  data_mux = REVISION_ID;
      `SEL_HALT_CTRL: data_mux = halt_reg;
      `SEL_PROG_CTRL: data_mux = prog_ctrl_reg;
      `SEL_PROG_DATA: data_mux = prog_data_reg;
      `SEL_PROG_STAT: data_mux = prog_status;
      `SEL_ADDR_HIGH: data_mux = addr_hi_reg;
      `SEL_ADDR_LOW:  data_mux = addr_lo_reg;
      `SEL_CHECK_0:   data_mux = check_reg[0];
      `SEL_CHECK_1:   data_mux = check_reg[1];
      `SEL_CHECK_2:   data_mux = check_reg[2];
      `SEL_CHECK_3:   data_mux = check_reg[3];
      default:        data_mux = `RST_BYTE;
    endcase
  end

  // Select register reads give status, never the stored selection
  wire [7:0] rd_value = ins_now[0] ? busy_status : data_mux;

  //////////////////////////////////////////////////////////////////////////
  // Frame decoder: start bit, two instruction bits, eight data bits
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    shift_next = shift_reg;
    if (ck_rise) begin
      unique case (state_reg)
        ST_IDLE: begin
          // A low data line at a rising edge opens a frame
          if (!dt_s2_reg) begin
            state_next = ST_INSTR;
            cnt_next   = `CNT_ZERO;
          end
        end
        ST_INSTR: begin
          cnt_next = cnt_reg + 3'h1;
          if (cnt_reg == `CNT_INS_LAST) begin
            cnt_next   = `CNT_ZERO;
            state_next = ins_now[1] ? ST_WDATA : ST_RDATA;
            if (!ins_now[1]) begin
              shift_next = rd_value;
            end
          end
        end
        ST_WDATA: begin
          shift_next = wr_byte;
          cnt_next   = cnt_reg + 3'h1;
          if (cnt_reg == `CNT_BYTE_LAST) begin
            state_next = ST_IDLE;
          end
        end
        ST_RDATA: begin
          shift_next = {1'b0, shift_reg[7:1]};
          cnt_next   = cnt_reg + 3'h1;
          if (cnt_reg == `CNT_BYTE_LAST) begin
            state_next = ST_IDLE;
          end
        end
      endcase
    end
  end

  // Frame registers and the shared data pin
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg         <= ST_IDLE;
      cnt_reg           <= `CNT_ZERO;
      shift_reg         <= `RST_BYTE;
      ins0_reg          <= 1'b0;
      o_debug_data_line <= 1'b0;
      o_debug_data_oe   <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      shift_reg <= shift_next;
      if (ck_rise && (state_reg == ST_INSTR) && (cnt_reg == `CNT_ZERO)) begin
        ins0_reg <= dt_s2_reg;
      end
      // Drive only during the read byte; released after its last edge
      o_debug_data_oe   <= (state_next == ST_RDATA);
      o_debug_data_line <= shift_next[0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register writes and the programming sequencer
  wire start_wr = wr_data && sel_pdata && !busy_reg;
  wire start_rd = rd_data && sel_pdata && !busy_reg;
  // Ops need the core halted; writes also need programming enabled
  wire wr_ok    = !i_wr_locked && halt_reg[`HALT_BIT] && prog_ctrl_reg[`PROG_EN_BIT];
  wire rd_ok    = !i_rd_locked && halt_reg[`HALT_BIT];

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      select_reg    <= `RST_BYTE;
      halt_reg      <= `RST_BYTE;
      prog_ctrl_reg <= `RST_BYTE;
      prog_data_reg <= `RST_BYTE;
      addr_hi_reg   <= `RST_BYTE;
      addr_lo_reg   <= `RST_BYTE;
      check_reg     <= '{default: `RST_BYTE};
      busy_reg      <= 1'b0;
      we_reg        <= 1'b0;
      error_reg     <= 1'b0;
    end else begin
      if (wr_addr) begin
        select_reg <= wr_byte;
      end
      // Data writes land where the selection points; others fall away
      if (wr_data) begin
        unique case (select_reg)
          `SEL_HALT_CTRL: halt_reg      <= wr_byte;
          `SEL_PROG_CTRL: prog_ctrl_reg <= wr_byte;
          `SEL_ADDR_HIGH: addr_hi_reg   <= wr_byte;
          `SEL_ADDR_LOW:  addr_lo_reg   <= wr_byte;
          `SEL_CHECK_0:   check_reg[0]  <= wr_byte;
          `SEL_CHECK_1:   check_reg[1]  <= wr_byte;
          `SEL_CHECK_2:   check_reg[2]  <= wr_byte;
          `SEL_CHECK_3:   check_reg[3]  <= wr_byte;
          default: ;
        endcase
      end
      // Data byte is frozen while an op runs so the write stays intact
      if (start_wr) begin
        prog_data_reg <= wr_byte;
        busy_reg      <= wr_ok;
        we_reg        <= 1'b1;
        error_reg     <= !wr_ok;
      end else if (start_rd) begin
        busy_reg  <= rd_ok;
        we_reg    <= 1'b0;
        error_reg <= !rd_ok;
      end else if (busy_reg && i_mem_ack) begin
        busy_reg <= 1'b0;
        if (!we_reg) begin
          prog_data_reg <= i_mem_rdata;
        end
      end
    end
  end

  // Outputs come straight from the registers above
  assign o_cpu_halt  = halt_reg[`HALT_BIT];
  assign o_mem_req   = busy_reg;
  assign o_mem_we    = we_reg;
  assign o_mem_addr  = {addr_hi_reg, addr_lo_reg};
  assign o_mem_wdata = prog_data_reg;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  chk_select_hold: assert property (wr_addr |=> select_reg == $past(wr_byte))
    else $error("select register missed its write");
  chk_id_route: assert property (rd_data && select_reg == `SEL_DEVICE_ID
    |=> shift_reg == DEVICE_ID ##1 o_debug_data_oe)
    else $error("device id not routed to read");
  chk_halt_write: assert property (wr_data && select_reg == `SEL_HALT_CTRL
    |=> o_cpu_halt == $past(wr_byte[`HALT_BIT]))
    else $error("halt control write lost");
  chk_ctrl_write: assert property (wr_data && select_reg == `SEL_PROG_CTRL
    |=> prog_ctrl_reg == $past(wr_byte))
    else $error("programming control write lost");
  chk_status_route: assert property (rd_data && select_reg == `SEL_PROG_STAT
    |=> shift_reg == {$past(i_wr_locked), $past(i_rd_locked), 5'h00, $past(error_reg)})
    else $error("programming status read wrong");
  chk_addr_write: assert property (wr_data && select_reg == `SEL_ADDR_LOW
    |=> o_mem_addr[7:0] == $past(wr_byte))
    else $error("address low byte write lost");
  chk_check_write: assert property (wr_data && select_reg == `SEL_CHECK_3
    |=> check_reg[3] == $past(wr_byte))
    else $error("check byte write lost");
  chk_busy_read: assert property (rd_fire && ins_now == `INS_ADDR_RD
    |=> shift_reg == {$past(busy_reg), 7'h00})
    else $error("status read does not show busy");
  chk_busy_end: assert property (busy_reg && i_mem_ack && !start_wr && !start_rd
    |=> !o_mem_req)
    else $error("busy not cleared on completion");
  chk_lock_error: assert property (start_wr && i_wr_locked
    |=> error_reg && !busy_reg)
    else $error("locked write not refused");
  chk_unmapped_read: assert property (rd_data && select_reg == 8'h55
    |=> shift_reg == `RST_BYTE)
    else $error("unmapped read not zero");
  chk_pin_release: assert property ((state_reg == ST_IDLE) && !ck_rise
    |=> !o_debug_data_oe)
    else $error("data pin driven outside a read");

endmodule

//--- bench/debug_adapter_model.sv
// Adapter model for the two-pin debug port: clock pin plus shared data line.
// Assumes the bench resolves the data wire (pull-up when nobody drives it).
`timescale 1ns/1ps

module debug_adapter_model (
  input  wire logic i_mclk,     // Bench clock, all changes land on its rises
  input  wire logic i_line,     // Resolved data wire
  output logic      o_clock,    // Adapter clock pin
  output logic      o_data,     // Adapter drive value
  output logic      o_data_oe   // High while adapter drives the wire
);
  // Clock rests low between frames; the wire is released
  initial begin
    o_clock   = 1'b0;
    o_data    = 1'b1;
    o_data_oe = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////
  // One 800 ns period: data set 300 ns before the rise, held 500 ns after
  task automatic pulse(input logic d, input logic drive, output logic q);
    @(posedge i_mclk);
    o_data    <= d;
    o_data_oe <= drive;
    repeat (3) @(posedge i_mclk);
    q = i_line;          // Device bit is settled just before the rise
    o_clock <= 1'b1;
    repeat (4) @(posedge i_mclk);
    o_clock <= 1'b0;
  endtask

  // Start bit, two instruction bits, then eight data bits LSB first
  task automatic frame(input logic [1:0] ins, input logic [7:0] wd, output logic [7:0] rd);
    logic q;
    logic wr;
    wr = ins[1];         // Codes 10 and 11 carry write data
    rd = 8'h00;
    pulse(1'b0, 1'b1, q);
    pulse(ins[0], 1'b1, q);
    pulse(ins[1], 1'b1, q);
    for (int k = 0; k < 8; k++) begin
      pulse(wd[k], wr, q);  // Released during reads so the device can answer
      rd[k] = q;
    end
    @(posedge i_mclk);
    o_data_oe <= 1'b0;
    repeat (4) @(posedge i_mclk);
  endtask
endmodule

//--- bench/test_two_wire_debug_register_select.sv
// Self-checking bench for the two-pin debug port register select logic.
// Assumes the adapter model drives the pins and the bench answers memory ops.
`timescale 1ns/1ps
`include "debug_port_map.svh"

module test_two_wire_debug_register_select;
  localparam logic [7:0] ID_VAL  = 8'h6B;  // Arbitrary identity value
  localparam logic [7:0] REV_VAL = 8'h02;  // Arbitrary identity value

  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ad_clock, ad_data, ad_oe, dev_data, dev_oe, cpu_halt;
  logic        mem_req, mem_we, last_we;
  logic        mem_ack = 1'b0;
  logic [15:0] mem_addr;
  logic [7:0]  mem_wdata, rd;
  logic [7:0]  mem_rdata = 8'h00;
  logic        wr_locked = 1'b0;
  logic        rd_locked = 1'b0;
  int          fails = 0, n_compared = 0, n_req = 0, mem_lat = 3, lat_cnt = 0;
  // Device drive wins; a pull-up holds the released wire high
  wire         line = dev_oe ? dev_data : (ad_oe ? ad_data : 1'b1);

  always #50 mclk = ~mclk;

  two_wire_debug_register_select #(.DEVICE_ID(ID_VAL), .REVISION_ID(REV_VAL)) i_dut (
    .i_mclk(mclk), .i_rst_n(rst_n), .i_debug_clock_line(ad_clock),
    .i_debug_data_line(line), .o_debug_data_line(dev_data), .o_debug_data_oe(dev_oe),
    .o_cpu_halt(cpu_halt), .o_mem_req(mem_req), .o_mem_we(mem_we), .o_mem_addr(mem_addr),
    .o_mem_wdata(mem_wdata), .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata),
    .i_wr_locked(wr_locked), .i_rd_locked(rd_locked));

  debug_adapter_model i_adapter (
    .i_mclk(mclk), .i_line(line), .o_clock(ad_clock), .o_data(ad_data), .o_data_oe(ad_oe));

  // Memory side: a pending op is answered after mem_lat plus one cycles by one ack pulse
  always @(posedge mclk) begin
    mem_ack <= 1'b0;
    if (mem_req === 1'b1 && !mem_ack) begin
      if (lat_cnt == 0) n_req <= n_req + 1;
      lat_cnt <= lat_cnt + 1;
      if (lat_cnt >= mem_lat) begin
        mem_ack <= 1'b1;
        last_we <= mem_we;
        lat_cnt <= 0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Every access goes through select and data frames on the two pins
  task automatic wr_reg(input logic [7:0] s, input logic [7:0] v);
    i_adapter.frame(`INS_ADDR_WR, s, rd);
    i_adapter.frame(`INS_DATA_WR, v, rd);
  endtask

  task automatic rd_reg(input logic [7:0] s, output logic [7:0] v);
    i_adapter.frame(`INS_ADDR_WR, s, rd);
    i_adapter.frame(`INS_DATA_RD, 8'h00, v);
  endtask

  // Polls only the top status bit; a bounded count guards a stuck busy flag
  task automatic poll_idle;
    logic [7:0] s;
    for (int k = 0; k < 20; k++) begin
      i_adapter.frame(`INS_ADDR_RD, 8'h00, s);
      if (s[7] === 1'b0) return;
    end
    fails++;
    summarize();
  endtask

  ////////////////////////////////////////////////////////////////////
  task automatic t_map;
    logic [7:0] v;
    logic [7:0] sel [8] = '{`SEL_HALT_CTRL, `SEL_CHECK_0, `SEL_CHECK_1, `SEL_CHECK_2,
                            `SEL_CHECK_3, `SEL_ADDR_LOW, `SEL_ADDR_HIGH, `SEL_PROG_CTRL};
    foreach (sel[k]) wr_reg(sel[k], sel[k] ^ 8'h5A);
    // Read back after all writes so an aliased target shows up
    foreach (sel[k]) begin
      rd_reg(sel[k], v);
      check(v, sel[k] ^ 8'h5A);
    end
    check(mem_addr, 16'hF5F4);
    wr_reg(`SEL_DEVICE_ID, 8'hFF);
    rd_reg(`SEL_DEVICE_ID, v);
    check(v, ID_VAL);
    wr_reg(`SEL_REVISION, 8'hFF);
    rd_reg(`SEL_REVISION, v);
    check(v, REV_VAL);
    wr_reg(8'h55, 8'hFF);
    rd_reg(8'h55, v);
    check(v, 8'h00);
    i_adapter.frame(`INS_ADDR_RD, 8'h00, v);
    check(v, 8'h00);
    $display("test map done");
  endtask

  task automatic t_prog_write;
    logic [7:0] v;
    int n0;
    wr_reg(`SEL_HALT_CTRL, 8'h01);
    check(cpu_halt, 1'b1);
    wr_reg(`SEL_PROG_CTRL, 8'h01);
    wr_reg(`SEL_ADDR_HIGH, 8'h12);
    wr_reg(`SEL_ADDR_LOW, 8'h34);
    mem_lat = 400;
    n0 = n_req;
    wr_reg(`SEL_PROG_DATA, 8'hC3);
    check({mem_req, mem_we, mem_addr, mem_wdata}, {2'b11, 16'h1234, 8'hC3});
    i_adapter.frame(`INS_ADDR_RD, 8'h00, v);
    check(v[7], 1'b1);
    i_adapter.frame(`INS_DATA_WR, 8'h77, rd);  // Dropped while busy
    poll_idle();
    check(mem_wdata, 8'hC3);
    check(16'(n_req - n0), 16'h0001);
    rd_reg(`SEL_PROG_STAT, v);
    check(v, 8'h00);
    $display("test program write done");
  endtask

  task automatic t_lock;
    logic [7:0] v;
    int n0;
    mem_lat = 3;
    n0 = n_req;
    @(posedge mclk);
    wr_locked <= 1'b1;
    wr_reg(`SEL_PROG_DATA, 8'h99);
    rd_reg(`SEL_PROG_STAT, v);
    check(v, 8'h81);
    @(posedge mclk);
    wr_locked <= 1'b0;
    rd_locked <= 1'b1;
    rd_reg(`SEL_PROG_DATA, v);
    rd_reg(`SEL_PROG_STAT, v);
    check(v, 8'h41);
    check(16'(n_req - n0), 16'h0000);
    @(posedge mclk);
    rd_locked <= 1'b0;
    mem_rdata <= 8'h3C;
    rd_reg(`SEL_PROG_DATA, v);  // Returns the held byte, launches a fetch
    check(v, 8'h99);
    poll_idle();
    check(last_we, 1'b0);
    i_adapter.frame(`INS_DATA_RD, 8'h00, v);
    check(v, 8'h3C);
    poll_idle();
    rd_reg(`SEL_PROG_STAT, v);
    check(v, 8'h00);
    $display("test lock done");
  endtask

  task automatic t_halt_off;
    logic [7:0] v;
    int n0;
    n0 = n_req;
    wr_reg(`SEL_HALT_CTRL, 8'h00);
    check(cpu_halt, 1'b0);
    wr_reg(`SEL_PROG_DATA, 8'h11);
    rd_reg(`SEL_PROG_STAT, v);
    check(v, 8'h01);
    check(16'(n_req - n0), 16'h0000);
    $display("test halt off done");
  endtask

  ////////////////////////////////////////////////////////////////////
  // Guard against a hang anywhere in the run
  initial begin
    repeat (90000) @(posedge mclk);
    fails++;
    summarize();
  end

  // Main sequence: reset for four cycles, then each scenario
  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_map();
    t_prog_write();
    t_lock();
    t_halt_off();
    summarize();
  end
endmodule
